/* orb_pkg.sv */
// shared constants and types for the reset and single-slot command block
package orb_pkg;
  localparam int ADDR_W = 8;
  // register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_DATA = 8'h04;
  localparam logic [7:0] OFF_PTR = 8'h08;
  localparam logic [7:0] OFF_CONFIG = 8'h0C;
  localparam logic [7:0] OFF_PORT = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
  // command codes and field positions
  localparam logic [7:0] CMD_RESET = 8'hB4;
  localparam logic [7:0] CMD_SLOT = 8'h87;
  localparam int SLOT_VALUE_BIT = 15;
  localparam int PSEL_LSB = 5;
  localparam int OD_BIT = 4;
  localparam int VAL_LSB = 0;
  localparam logic [2:0] PSEL_RSTL = 3'h0;
  localparam logic [2:0] PSEL_MSP = 3'h1;
  localparam logic [2:0] PSEL_W0L = 3'h2;
  localparam logic [2:0] PSEL_REC0 = 3'h3;
  localparam logic [2:0] PSEL_WEAK_PULLUP_RESISTANCE = 3'h4;
  localparam logic PTR_STATUS = 1'h0;
  localparam logic PTR_CONFIG = 1'h1;
  // reset values
  localparam logic [3:0] RSTL_CODE_RST = 4'h6;
  localparam logic [3:0] MSP_CODE_RST = 4'h6;
  localparam logic [3:0] W0L_CODE_RST = 4'h6;
  localparam logic [3:0] REC0_CODE_RST = 4'h0;
  localparam logic [3:0] WEAK_PULLUP_RESISTANCE_CODE_RST = 4'h0;
  localparam logic [3:0] WEAK_PULLUP_RESISTANCE_HIGH_CODE = 4'h6;
  // timing: clock in ns, start limit in ps, base/step/cap/fixed figures in quarter-microseconds
  localparam int CLOCK_NS = 10;
  localparam int QUANTUM_NS = 250;
  localparam int TICK_CYC = QUANTUM_NS / CLOCK_NS;
  localparam int START_MAX_PS = 262500;
  localparam int START_MAX_CYC = START_MAX_PS / (CLOCK_NS * 1000);
  localparam logic [11:0] RSTL_STD_BASE_Q = 12'h06E0;
  localparam logic [11:0] RSTL_STD_STEP_Q = 12'h0050;
  localparam logic [11:0] RSTL_OD_BASE_Q = 12'h00B0;
  localparam logic [11:0] RSTL_OD_STEP_Q = 12'h0008;
  localparam logic [11:0] MSP_STD_BASE_Q = 12'h00E8;
  localparam logic [11:0] MSP_STD_CAP_Q = 12'h0130;
  localparam logic [11:0] MSP_OD_BASE_Q = 12'h0016;
  localparam logic [11:0] MSP_OD_CAP_Q = 12'h002C;
  localparam logic [11:0] W0L_STD_BASE_Q = 12'h00D0;
  localparam logic [11:0] W0L_STD_CAP_Q = 12'h0118;
  localparam logic [11:0] W0L_OD_BASE_Q = 12'h0014;
  localparam logic [11:0] W0L_OD_CAP_Q = 12'h0028;
  localparam logic [11:0] STD_STEP_Q = 12'h0008;
  localparam logic [11:0] OD_STEP_Q = 12'h0002;
  localparam logic [11:0] REC0_LOW_Q = 12'h000B;
  localparam logic [11:0] REC0_BASE_Q = 12'h0015;
  localparam logic [11:0] REC0_STEP_Q = 12'h000A;
  localparam logic [11:0] REC0_CAP_Q = 12'h0065;
  localparam logic [11:0] NO_CAP_Q = 12'hFFF;
  localparam logic [11:0] W1L_STD_Q = 12'h0018;
  localparam logic [11:0] W1L_OD_Q = 12'h0004;
  localparam logic [11:0] MSR_STD_Q = 12'h0028;
  localparam logic [11:0] MSR_OD_Q = 12'h0008;
  localparam logic [11:0] SI_STD_Q = 12'h0020;
  localparam logic [11:0] SI_OD_Q = 12'h0004;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_RST = 3'h2,
    ST_SLOT = 3'h4
  } orb_state_t;
  typedef struct packed {
    logic dir;
    logic single_bit_result;
    logic sd;
    logic presence_pulse_flag;
    logic busy;
  } orb_status_t;
  typedef struct packed {
    logic strong_pullup_enable;
    logic active_pullup_enable;
    logic speed;
  } orb_config_t;
  typedef struct packed {
    logic refused;
    logic slotDone;
    logic resetDone;
  } orb_events_t;
  localparam orb_config_t CONFIG_RST = 3'h0;
endpackage : orb_pkg

/* orb_reset_bit.sv */
// reset/presence and single time slot command engine with apb registers
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
// Summary of operation
// R01 - command B4h starts reset/presence cycle
// R02 - sample short and presence, report flags
// R03 - busy reset command refused, not acknowledged; the code completes it with pready high and pslverr set instead
// R04 - reset lasts twice reset-low time
// R05 - reset line activity starts within 262.5ns
// R06 - busy two reset-lows, flags at offsets
// R07 - after reset, pointer on status
// R08 - command 87h, slot value in bit 15
// R09 - value 0 writes zero, 1 writes one
// R10 - sample line at bit-sample time, store result
// R11 - busy slot command refused entirely
// R12 - slot starts promptly, lasts one slot
// R13 - busy for one slot, direction may change
// R14 - after slot, pointer on status
// R15 - slot honours speed, pullups, current timings
// R16 - separate standard and overdrive timing sets
// R17 - counter-timed instants, busy until done
module orb_reset_bit #(
  parameter int TICK_CYCLES = orb_pkg::TICK_CYC,
  parameter int CNT_W = 20
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [orb_pkg::ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic lineIn,
  output logic lineOut,
  output logic lineOe,
  output logic strongPullup,
  output logic activePullup,
  output logic weakPullupHigh
);
  import orb_pkg::*;

  if (TICK_CYCLES < 1) begin : g_chk_tick
    $error("TICK_CYCLES must be at least one");
  end
  if (2 * 4096 * TICK_CYCLES >= 2 ** CNT_W) begin : g_chk_cnt
    $error("CNT_W too narrow for longest reset");
  end
  if (START_MAX_CYC < 2) begin : g_chk_start
    $error("start latency of two cycles exceeds limit");
  end

  orb_state_t state;
  orb_status_t status;
  orb_config_t cfg;
  orb_events_t irqStat;
  orb_events_t irqMask;
  orb_events_t ev;
  logic [3:0] rstlCode [2];
  logic [3:0] mspCode [2];
  logic [3:0] w0lCode [2];
  logic [3:0] rec0Code;
  logic [3:0] rwpuCode;
  logic readPtr;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] lowCyc;
  logic [CNT_W-1:0] sampACyc;
  logic [CNT_W-1:0] sampBCyc;
  logic [CNT_W-1:0] endCyc;
  logic lineMeta;
  logic lineSync;
  logic setup;
  logic access;
  logic busy;
  logic writeCmd;
  logic knownCmd;
  logic cmdAccept;
  logic cmdRefused;
  logic portWrite;
  logic portBad;
  logic mapped;
  logic driveLow;
  logic cmdDone;
  logic od;
  logic [11:0] rstlQ;
  logic [11:0] mspQ;
  logic [11:0] w0lQ;
  logic [11:0] rec0Q;
  logic [11:0] w1lQ;
  logic [11:0] msrQ;
  logic [11:0] siQ;

  function automatic logic [11:0] stepCap(input logic [11:0] base, input logic [11:0] step,
                                          input logic [3:0] n, input logic [11:0] cap);
    logic [15:0] v;
    v = {4'h0, base} + 16'(step) * 16'(n);
    stepCap = (v > {4'h0, cap}) ? cap : v[11:0];
  endfunction : stepCap

  function automatic logic [CNT_W-1:0] toCyc(input logic [11:0] q);
    toCyc = CNT_W'(q) * CNT_W'(TICK_CYCLES);
  endfunction : toCyc

  // line level crosses in through two flops
  always_ff @(posedge clock) begin
    lineMeta <= lineIn;
    lineSync <= lineMeta;
  end

  // apb decode; zero wait states
  assign pready = 1'b1;
  assign setup = psel && !penable;
  assign access = psel && penable;
  assign busy = (state != ST_IDLE);
  assign writeCmd = access && pwrite && (paddr == OFF_CMD);
  assign knownCmd = (pwdata[7:0] == CMD_RESET) || (pwdata[7:0] == CMD_SLOT);
  // R03 busy refusal
  // R11 busy refusal
  assign cmdRefused = writeCmd && (busy || !knownCmd);
  assign cmdAccept = writeCmd && !busy && knownCmd;
  assign portWrite = access && pwrite && (paddr == OFF_PORT);
  assign portBad = (pwdata[PSEL_LSB +: 3] > PSEL_WEAK_PULLUP_RESISTANCE);
  always_comb begin
    if (paddr == OFF_CMD) begin
      mapped = 1'b1;
    end else if (paddr == OFF_DATA || paddr == OFF_PTR || paddr == OFF_CONFIG) begin
      mapped = 1'b1;
    end else if (paddr == OFF_PORT || paddr == OFF_STATUS) begin
      mapped = 1'b1;
    end else if (paddr == OFF_IRQ_STAT || paddr == OFF_IRQ_MASK) begin
      mapped = 1'b1;
    end else begin
      mapped = 1'b0;
    end
  end
  // refusal shows as pslverr, standing in for a withheld acknowledge
  assign pslverr = access && (!mapped || cmdRefused || (portWrite && portBad));

  // R16 speed-selected timing sets
  assign od = cfg.speed;
  always_comb begin
    rstlQ = od ? stepCap(RSTL_OD_BASE_Q, RSTL_OD_STEP_Q, rstlCode[1], NO_CAP_Q)
               : stepCap(RSTL_STD_BASE_Q, RSTL_STD_STEP_Q, rstlCode[0], NO_CAP_Q);
    mspQ = od ? stepCap(MSP_OD_BASE_Q, OD_STEP_Q, (mspCode[1] > 4'h1) ? mspCode[1] - 4'h1 : 4'h0,
                        MSP_OD_CAP_Q)
              : stepCap(MSP_STD_BASE_Q, STD_STEP_Q, (mspCode[0] > 4'h1) ? mspCode[0] - 4'h1 : 4'h0,
                        MSP_STD_CAP_Q);
    w0lQ = od ? stepCap(W0L_OD_BASE_Q, OD_STEP_Q, w0lCode[1], W0L_OD_CAP_Q)
              : stepCap(W0L_STD_BASE_Q, STD_STEP_Q, w0lCode[0], W0L_STD_CAP_Q);
    rec0Q = (rec0Code < 4'h6) ? REC0_LOW_Q
                              : stepCap(REC0_BASE_Q, REC0_STEP_Q, rec0Code - 4'h6, REC0_CAP_Q);
    w1lQ = od ? W1L_OD_Q : W1L_STD_Q;
    msrQ = od ? MSR_OD_Q : MSR_STD_Q;
    siQ = od ? SI_OD_Q : SI_STD_Q;
  end

  // port parameter writes
  always_ff @(posedge clock) begin
    if (srst) begin
      rstlCode[0] <= RSTL_CODE_RST;
      rstlCode[1] <= RSTL_CODE_RST;
      mspCode[0] <= MSP_CODE_RST;
      mspCode[1] <= MSP_CODE_RST;
      w0lCode[0] <= W0L_CODE_RST;
      w0lCode[1] <= W0L_CODE_RST;
      rec0Code <= REC0_CODE_RST;
      rwpuCode <= WEAK_PULLUP_RESISTANCE_CODE_RST;
    end else if (portWrite && !portBad) begin
      case (pwdata[PSEL_LSB +: 3])
        PSEL_RSTL: rstlCode[pwdata[OD_BIT]] <= pwdata[VAL_LSB +: 4];
        PSEL_MSP: mspCode[pwdata[OD_BIT]] <= pwdata[VAL_LSB +: 4];
        PSEL_W0L: w0lCode[pwdata[OD_BIT]] <= pwdata[VAL_LSB +: 4];
        PSEL_REC0: rec0Code <= pwdata[VAL_LSB +: 4];
        default: rwpuCode <= pwdata[VAL_LSB +: 4];
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      weakPullupHigh <= 1'b0;
    end else begin
      weakPullupHigh <= (rwpuCode >= WEAK_PULLUP_RESISTANCE_HIGH_CODE);
    end
  end

  // device configuration; strong pullup is one-shot, dropped after use
  always_ff @(posedge clock) begin
    if (srst) begin
      cfg <= CONFIG_RST;
    end else if (access && pwrite && paddr == OFF_CONFIG) begin
      cfg <= orb_config_t'(pwdata[2:0]);
    end else if (state == ST_SLOT && cmdDone) begin
      cfg.strong_pullup_enable <= 1'b0;
    end
  end

  // R17 command sequencer on cycle counter
  assign cmdDone = (cnt == endCyc - CNT_W'(1));
  always_ff @(posedge clock) begin
    if (srst) begin
      state <= ST_IDLE;
      cnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= '0;
          // R01 reset start
          if (cmdAccept && pwdata[7:0] == CMD_RESET) begin
            state <= ST_RST;
          // R08 slot start
          end else if (cmdAccept) begin
            state <= ST_SLOT;
          end
        end
        ST_RST, ST_SLOT: begin
          cnt <= cnt + CNT_W'(1);
          if (cmdDone) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // timing latched at start so mid-command writes cannot disturb it
  always_ff @(posedge clock) begin
    if (srst) begin
      lowCyc <= '0;
      sampACyc <= '0;
      sampBCyc <= '0;
      endCyc <= CNT_W'(1);
    end else if (cmdAccept && pwdata[7:0] == CMD_RESET) begin
      // R04 twice reset-low
      lowCyc <= toCyc(rstlQ);
      sampACyc <= toCyc(rstlQ) + toCyc(siQ);
      sampBCyc <= toCyc(rstlQ) + toCyc(mspQ);
      endCyc <= toCyc(rstlQ) + toCyc(rstlQ);
    end else if (cmdAccept) begin
      // R09 slot low time
      // R15 current timings apply
      lowCyc <= pwdata[SLOT_VALUE_BIT] ? toCyc(w1lQ) : toCyc(w0lQ);
      sampACyc <= toCyc(msrQ);
      sampBCyc <= toCyc(w0lQ) + toCyc(rec0Q);
      endCyc <= toCyc(w0lQ) + toCyc(rec0Q);
    end
  end

  // R05 line driven low on the second edge after acceptance
  // R12 slot starts promptly
  assign driveLow = busy && (cnt < lowCyc);
  always_ff @(posedge clock) begin
    if (srst) begin
      lineOe <= 1'b0;
      lineOut <= 1'b0;
      activePullup <= 1'b0;
    end else begin
      lineOe <= driveLow || strongPullup;
      lineOut <= !driveLow && strongPullup;
      activePullup <= cfg.active_pullup_enable && busy && !driveLow;
    end
  end

  // strong pullup holds after a slot until next command
  always_ff @(posedge clock) begin
    if (srst) begin
      strongPullup <= 1'b0;
    end else if (cmdAccept) begin
      strongPullup <= 1'b0;
    end else if (state == ST_SLOT && cmdDone && cfg.strong_pullup_enable) begin
      strongPullup <= 1'b1;
    end
  end

  // status flags
  always_ff @(posedge clock) begin
    if (srst) begin
      status <= '0;
    end else begin
      // R06 busy for command length
      status.busy <= (cmdAccept || busy) && !(busy && cmdDone);
      if (state == ST_RST && cnt == sampACyc) begin
        // R02 short sample
        status.sd <= !lineSync;
      end
      if (state == ST_RST && cnt == sampBCyc) begin
        // R02 presence sample
        status.presence_pulse_flag <= !lineSync;
      end
      if (state == ST_SLOT && cnt == sampACyc) begin
        // R10 bit sample
        // R13 direction follows sample
        status.single_bit_result <= lineSync;
        status.dir <= lineSync;
      end
    end
  end

  // read pointer
  always_ff @(posedge clock) begin
    if (srst) begin
      readPtr <= PTR_STATUS;
    end else if (cmdAccept) begin
      // R07 R14 pointer to status
      readPtr <= PTR_STATUS;
    end else if (access && pwrite && paddr == OFF_PTR) begin
      readPtr <= pwdata[0];
    end else if (access && pwrite && paddr == OFF_CONFIG) begin
      readPtr <= PTR_CONFIG;
    end
  end

  // read data captured in setup, presented in access
  always_ff @(posedge clock) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      if (paddr == OFF_DATA) begin
        prdata <= (readPtr == PTR_STATUS) ? 32'(status) : 32'(cfg);
      end else if (paddr == OFF_PTR) begin
        prdata <= 32'(readPtr);
      end else if (paddr == OFF_CONFIG) begin
        prdata <= 32'(cfg);
      end else if (paddr == OFF_PORT) begin
        prdata <= {12'h000, rwpuCode, rec0Code, w0lCode[1], w0lCode[0], 4'h0};
      end else if (paddr == OFF_STATUS) begin
        prdata <= 32'(status);
      end else if (paddr == OFF_IRQ_STAT) begin
        prdata <= 32'(irqStat);
      end else if (paddr == OFF_IRQ_MASK) begin
        prdata <= 32'(irqMask);
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // interrupts: clear only what the read reported, so new events survive
  assign ev.resetDone = (state == ST_RST) && cmdDone;
  assign ev.slotDone = (state == ST_SLOT) && cmdDone;
  assign ev.refused = cmdRefused;
  always_ff @(posedge clock) begin
    if (srst) begin
      irqStat <= '0;
      irqMask <= '0;
      irq <= 1'b0;
    end else begin
      if (access && !pwrite && paddr == OFF_IRQ_STAT) begin
        irqStat <= (irqStat & ~orb_events_t'(prdata[2:0])) | ev;
      end else begin
        irqStat <= irqStat | ev;
      end
      if (access && pwrite && paddr == OFF_IRQ_MASK) begin
        irqMask <= orb_events_t'(pwdata[2:0]);
      end
      irq <= |(irqStat & irqMask);
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  sequence acceptReset;
    cmdAccept && pwdata[7:0] == CMD_RESET;
  endsequence
  sequence acceptSlot;
    cmdAccept && pwdata[7:0] == CMD_SLOT;
  endsequence
  sequence lineLowTwo;
    (lineOe && !lineOut) [*2];
  endsequence

  reset_start_a: assert property (acceptReset |=> ##1 lineLowTwo) // R05
    else $error("reset did not drive line low promptly");
  slot_start_a: assert property (acceptSlot |=> ##1 lineOe && !lineOut) // R12
    else $error("slot did not drive line low promptly");
  busy_refuse_a: assert property (writeCmd && busy |-> pslverr ##1 $stable(lowCyc)) // R03
    else $error("busy command not refused");
  // a refused write in the command's last cycle still lets it finish
  slot_refuse_a: assert property (writeCmd && busy && !cmdDone // R11
                                  |=> $stable(endCyc) && state == $past(state))
    else $error("busy slot command altered state");
  reset_len_a: assert property (state == ST_RST && cnt == endCyc - CNT_W'(1)
                                |=> !busy && status.busy == 1'b0) // R04
    else $error("reset did not end at twice reset-low");
  busy_flag_a: assert property (acceptReset |=> status.busy && busy) // R06
    else $error("busy flag not raised at reset start");
  presence_flag_a: assert property (state == ST_RST && cnt == sampBCyc
                                    |=> status.presence_pulse_flag == !$past(lineSync)) // R02
    else $error("presence flag not updated from line");
  sbr_sample_a: assert property (state == ST_SLOT && cnt == sampACyc
                                 |=> status.single_bit_result == $past(lineSync)) // R10
    else $error("slot result not sampled");
  slot_busy_a: assert property (state == ST_SLOT && !cmdDone |=> status.busy && busy) // R13
    else $error("slot busy dropped early");
  read_ptr_a: assert property (cmdAccept |=> readPtr == PTR_STATUS) // R14
    else $error("read pointer not on status");
  low_time_a: assert property (acceptSlot |=> // R09
                               lowCyc == ($past(pwdata[SLOT_VALUE_BIT]) ? toCyc(w1lQ) : toCyc(w0lQ)))
    else $error("slot low time wrong for value");
endmodule : orb_reset_bit

/* orb_line_slave.sv */
// behavioural slave on the single-wire line: presence, read bits, shorts
`timescale 1ns/1ps
module orb_line_slave #(
  parameter int RESET_MIN = 400,
  parameter int PRES_WAIT = 80,
  parameter int PRES_LEN = 400,
  parameter int READ_HOLD = 120
) (
  input wire logic clock,
  input wire logic lineOut,
  input wire logic lineOe,
  input wire logic presenceOn,
  input wire logic shortOn,
  input wire logic readBit,
  output logic slaveLow
);
  logic masterLow;
  logic lowPrev = 1'b0;
  int lowCnt = 0;
  int presCnt = 0;
  int holdCnt = 0;
  assign masterLow = lineOe && !lineOut;
  // counts are clock cycles; only standard-speed resets earn a presence reply
  always @(posedge clock) begin
    lowPrev <= masterLow;
    lowCnt <= masterLow ? lowCnt + 1 : 0;
    if (!masterLow && lowPrev && lowCnt >= RESET_MIN && presenceOn) begin
      presCnt <= 1;
    end else if (presCnt != 0 && presCnt < PRES_WAIT + PRES_LEN) begin
      presCnt <= presCnt + 1;
    end else begin
      presCnt <= 0;
    end
    // a zero read bit stretches the master's low past the sample point
    if (masterLow && !lowPrev && !readBit) begin
      holdCnt <= READ_HOLD;
    end else if (holdCnt != 0) begin
      holdCnt <= holdCnt - 1;
    end
  end
  // released line rises through the pull-up
  assign slaveLow = shortOn || holdCnt != 0 || presCnt > PRES_WAIT;
endmodule : orb_line_slave

/* test_onewire_reset_and_bit_commands.sv */
// self-checking bench for the reset and single-slot command block
`timescale 1ns/1ps
module test_onewire_reset_and_bit_commands;
  import orb_pkg::*;
  localparam int RSTL_STD = 2240;
  localparam int RSTL_OD0 = 176;
  localparam int W1L_STD = 24;
  localparam int W0L_STD = 256;
  localparam int SLOT_STD = 267;
  localparam int SLOT_OD = 43;
  logic clock = 1'b0;
  logic srst, psel, penable, pwrite, pready, pslverr, irq, lineIn, lineOut, lineOe;
  logic strongPullup, activePullup, weakPullupHigh, slaveLow, presenceOn, shortOn, readBit;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, rdS;
  logic err, errS;
  logic lowPrev = 1'b0;
  logic apuSeen = 1'b0;
  int errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int cmdCyc = 0;
  int lowStart = 0;
  int lowLen = 0;
  int startGap = 0;
  int busyLen;
  logic [31:0] statTab [3] = '{32'h0000_0002, 32'h0000_0000, 32'h0000_0006};
  logic [2:0] slotTab [3] = '{3'b111, 3'b100, 3'b010};
  always #5 clock = ~clock;
  orb_reset_bit #(.TICK_CYCLES(1), .CNT_W(20)) dut_u (.clock(clock), .srst(srst),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .lineIn(lineIn),
    .lineOut(lineOut), .lineOe(lineOe), .strongPullup(strongPullup),
    .activePullup(activePullup), .weakPullupHigh(weakPullupHigh));
  orb_line_slave slave_u (.clock(clock), .lineOut(lineOut), .lineOe(lineOe),
    .presenceOn(presenceOn), .shortOn(shortOn), .readBit(readBit), .slaveLow(slaveLow));
  assign lineIn = !((lineOe && !lineOut) || slaveLow);
  // line monitor: start gap and low length, plus the hang limit
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (psel && penable && pwrite && paddr == OFF_CMD && !pslverr) cmdCyc <= cyc;
    // answer taken at the completing edge, before the design moves on
    if (psel && penable && pready) begin
      rdS <= prdata;
      errS <= pslverr;
    end
    if (lineOe && !lineOut && !lowPrev) begin
      startGap <= cyc - cmdCyc;
      lowStart <= cyc;
    end
    if (!(lineOe && !lineOut) && lowPrev) lowLen <= cyc - lowStart;
    lowPrev <= lineOe && !lineOut;
    if (activePullup) apuSeen <= 1'b1;
    if (cyc >= 40000) begin
      errors = errors + 1;
      summarize();
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1) @(posedge clock);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
    rd = rdS;
    err = errS;
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d, input logic expErr);
    apb(1'b1, a, d);
    check(32'(err), 32'(expErr));
  endtask : wr
  task rdChk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask : rdChk
  task inRange(input int v, input int lo, input int hi);
    check(32'(v >= lo && v <= hi), 32'h0000_0001);
  endtask : inRange
  // accepted command, a refused repeat while busy, then poll busy away
  task runCmd(input logic [31:0] d);
    wr(OFF_CMD, d, 1'b0);
    wr(OFF_CMD, d, 1'b1);
    for (int i = 0; i < 3000; i++) begin
      apb(1'b0, OFF_DATA, 32'h0000_0000);
      if (rd[0] === 1'b0) break;
    end
    busyLen = cyc - cmdCyc;
    inRange(startGap, 0, START_MAX_CYC);
  endtask : runCmd
  task summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : summarize
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    presenceOn = 1'b1;
    shortOn = 1'b0;
    readBit = 1'b1;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    @(posedge clock);
    rdChk(OFF_PTR, 32'h0000_0000);
    rdChk(OFF_CONFIG, 32'h0000_0000);
    rdChk(OFF_PORT, 32'h0000_0660);
    rdChk(OFF_IRQ_STAT, 32'h0000_0000);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check(32'(err), 32'h0000_0001);
    wr(OFF_IRQ_MASK, 32'h0000_0007, 1'b0);
    // reset cycles: presence, none, shorted line
    for (int k = 0; k < 3; k++) begin
      presenceOn <= (k == 0);
      shortOn <= (k == 2);
      runCmd(32'(CMD_RESET));
      check(32'(lowLen), 32'(RSTL_STD));
      inRange(busyLen, 2 * RSTL_STD, 2 * RSTL_STD + START_MAX_CYC);
      rdChk(OFF_PTR, 32'h0000_0000);
      rdChk(OFF_DATA, statTab[k]);
      check(32'(irq), 32'h0000_0001);
      rdChk(OFF_IRQ_STAT, 32'h0000_0005);
      repeat (2) @(posedge clock);
      check(32'(irq), 32'h0000_0000);
    end
    shortOn <= 1'b0;
    wr(OFF_IRQ_MASK, 32'h0000_0000, 1'b0);
    // slot table: value, read bit, expected result
    for (int k = 0; k < 3; k++) begin
      readBit <= slotTab[k][1];
      runCmd({16'h0000, slotTab[k][2], 7'h55, CMD_SLOT});
      check(32'(lowLen), slotTab[k][2] ? 32'(W1L_STD) : 32'(W0L_STD));
      inRange(busyLen, SLOT_STD, SLOT_STD + START_MAX_CYC);
      // presence and short flags stay from the last shorted reset
      rdChk(OFF_DATA, slotTab[k][0] ? 32'h0000_001E : 32'h0000_0006);
      check(32'(irq), 32'h0000_0000);
    end
    rdChk(OFF_IRQ_STAT, 32'h0000_0006);
    // overdrive timings and pullup settings
    wr(OFF_PORT, 32'h0000_0010, 1'b0);
    wr(OFF_PORT, 32'h0000_0086, 1'b0);
    wr(OFF_PORT, 32'h0000_00A0, 1'b1);
    rdChk(OFF_PORT, 32'h0006_0660);
    check(32'(weakPullupHigh), 32'h0000_0001);
    wr(OFF_CONFIG, 32'h0000_0003, 1'b0);
    rdChk(OFF_PTR, 32'h0000_0001);
    rdChk(OFF_DATA, 32'h0000_0003);
    runCmd(32'(CMD_RESET));
    check(32'(lowLen), 32'(RSTL_OD0));
    inRange(busyLen, 2 * RSTL_OD0, 2 * RSTL_OD0 + START_MAX_CYC);
    check(32'(apuSeen), 32'h0000_0001);
    wr(OFF_CONFIG, 32'h0000_0005, 1'b0);
    runCmd({16'h0000, 1'b1, 7'h00, CMD_SLOT});
    check(32'(lowLen), 32'h0000_0004);
    inRange(busyLen, SLOT_OD, SLOT_OD + START_MAX_CYC);
    check(32'(strongPullup), 32'h0000_0001);
    rdChk(OFF_CONFIG, 32'h0000_0001);
    wr(OFF_CMD, 32'h0000_00A5, 1'b1);
    runCmd(32'(CMD_RESET));
    check(32'(strongPullup), 32'h0000_0000);
    summarize();
  end
endmodule : test_onewire_reset_and_bit_commands
